// File: include/sse_pkg.sv
// package for the shift, subtract and word store execution block
package sse_pkg;

    localparam logic [5:0] OP_REG_FORMAT = 6'h00;
    localparam logic [5:0] OP_WORD_STORE = 6'h2b;
    localparam logic [5:0] OP_COPROC0_ST = 6'h38;
    localparam logic [5:0] OP_COPROC1_ST = 6'h39;
    localparam logic [5:0] OP_COPROC2_ST = 6'h3a;
    localparam logic [5:0] FN_SHIFT_RV   = 6'h06;
    localparam logic [5:0] FN_CHECKED    = 6'h22;
    localparam logic [5:0] FN_WRAPPING   = 6'h23;

    localparam int OPC_HI   = 31;
    localparam int OPC_LO   = 26;
    localparam int SRCA_HI  = 25;
    localparam int SRCA_LO  = 21;
    localparam int SECB_HI  = 20;
    localparam int SECB_LO  = 16;
    localparam int DEST_HI  = 15;
    localparam int DEST_LO  = 11;
    localparam int SHAM_HI  = 10;
    localparam int SHAM_LO  = 6;
    localparam int FUNC_HI  = 5;
    localparam int FUNC_LO  = 0;
    localparam int OFFS_HI  = 15;
    localparam int SHIFT_W  = 5;

    localparam logic [63:0] RESULT_RESET = 64'h0000_0000_0000_0000;

    typedef enum logic [2:0] {
        SSE_EXC_NONE,
        SSE_EXC_OVERFLOW,
        SSE_EXC_ADDR_ERR,
        SSE_EXC_COP_UNUSABLE,
        SSE_EXC_RESERVED,
        SSE_EXC_TLB_MISS,
        SSE_EXC_TLB_INVALID,
        SSE_EXC_TLB_MOD
    } sse_exc_type;

    typedef enum logic [2:0] {
        SSE_OP_NONE,
        SSE_OP_SHIFT,
        SSE_OP_CHECKED,
        SSE_OP_WRAPPING,
        SSE_OP_STORE,
        SSE_OP_COP_STORE
    } sse_op_type;

    // one issued instruction with its register operands
    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [63:0] source_reg_a;
        logic [63:0] second_operand_reg;
        logic        mode64;
        logic        cop_usable1;
        logic        cop_usable2;
    } sse_issue_type;

    // register write-back
    typedef struct packed {
        logic        valid;
        logic [4:0]  dest;
        logic [63:0] value;
    } sse_wb_type;

    // store request toward translation and memory
    typedef struct packed {
        logic        valid;
        logic        from_coproc;
        logic [1:0]  coproc_num;
        logic [4:0]  coproc_reg;
        logic [63:0] vaddr;
        logic [31:0] data;
    } sse_store_type;

    // response from translation and memory for the pending store
    typedef struct packed {
        logic        done;
        logic        tlb_miss;
        logic        tlb_invalid;
        logic        tlb_mod;
        logic        bus_error;
    } sse_mem_resp_type;

endpackage

// File: rtl/sse_addr_gen.sv
// effective address generation and word alignment check
`timescale 1ns/1ps
module sse_addr_gen (
    input  wire logic [63:0] base,
    input  wire logic [15:0] offset,
    input  wire logic        mode64,
    output logic      [63:0] vaddr,
    output logic             misaligned
);
    logic [63:0] sum;

    always_comb begin
        sum = base + {{48{offset[15]}}, offset};
        // in 32-bit mode the address is a sign-extended 32-bit value
        if (mode64) begin
            vaddr = sum;
        end else begin
            vaddr = {{32{sum[31]}}, sum[31:0]};
        end
        misaligned = (vaddr[1:0] != 2'b00);
    end
endmodule

// File: rtl/sse_exec.sv
// execution of variable shift, subtracts and word stores
// Summary of operation
// - variable logical right shift of low word by low five bits of source A
// - in 64-bit mode results are 32-bit values sign-extended from bit 31
// - checked difference writes source A minus second operand to destination
// - checked difference overflows when carries out of bits 30 and 31 differ
// - on overflow the destination is left unchanged, no write-back
// - wrapping difference gives same result and never overflows
// - store address is sign-extended 16-bit offset plus base register
// - word store writes low 32 bits of second operand as one word
// - word store takes address error when low two address bits nonzero
// - coprocessor store takes address error when low two bits nonzero
// - coprocessor store with coprocessor zero is an invalid encoding
// - word store reports translation miss, invalid, modify, bus, address
// - word store decodes from major opcode 101011 with base, source, offset
// - coprocessor store opcodes 111001 and 111010, adds unusable fault
`timescale 1ns/1ps
module sse_exec (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire sse_pkg::sse_issue_type    issue,
    output logic                           issue_ready,
    output sse_pkg::sse_wb_type            wb,
    output sse_pkg::sse_store_type         store_req,
    input  wire logic                      store_ready,
    input  wire logic [31:0]               coproc_data,
    input  wire sse_pkg::sse_mem_resp_type mem_resp,
    output logic                           exc_valid,
    output sse_pkg::sse_exc_type           exc_code,
    output logic                           store_done
);
    typedef enum logic [1:0] {
        SSE_IDLE,
        SSE_FETCH,
        SSE_REQ,
        SSE_WAIT
    } sse_state_type;

    typedef struct packed {
        sse_state_type          state;
        sse_pkg::sse_wb_type    wb;
        sse_pkg::sse_store_type st;
        logic                   exc_valid;
        sse_pkg::sse_exc_type   exc_code;
        logic                   store_done;
    } sse_regs_type;

    sse_regs_type r;
    sse_regs_type next_r;

    logic [5:0]  opc;
    logic [5:0]  func;
    logic [4:0]  sham;
    logic [4:0]  shift_amt;
    logic [31:0] shift_res;
    logic [32:0] diff;
    logic        carry30;
    logic        overflow;
    logic [63:0] vaddr;
    logic        misaligned;
    sse_pkg::sse_op_type op;

    assign opc  = issue.instr[sse_pkg::OPC_HI:sse_pkg::OPC_LO];
    assign func = issue.instr[sse_pkg::FUNC_HI:sse_pkg::FUNC_LO];
    assign sham = issue.instr[sse_pkg::SHAM_HI:sse_pkg::SHAM_LO];

    sse_addr_gen u_addr (
        .base       (issue.source_reg_a),
        .offset     (issue.instr[sse_pkg::OFFS_HI:0]),
        .mode64     (issue.mode64),
        .vaddr      (vaddr),
        .misaligned (misaligned)
    );

    always_comb begin
        op = sse_pkg::SSE_OP_NONE;
        if (opc == sse_pkg::OP_REG_FORMAT && sham == 5'h00) begin
            case (func)
                sse_pkg::FN_SHIFT_RV: op = sse_pkg::SSE_OP_SHIFT;
                sse_pkg::FN_CHECKED:  op = sse_pkg::SSE_OP_CHECKED;
                sse_pkg::FN_WRAPPING: op = sse_pkg::SSE_OP_WRAPPING;
                default:              op = sse_pkg::SSE_OP_NONE;
            endcase
        end else if (opc == sse_pkg::OP_WORD_STORE) begin
            op = sse_pkg::SSE_OP_STORE;
        end else if (opc == sse_pkg::OP_COPROC0_ST
                     || opc == sse_pkg::OP_COPROC1_ST
                     || opc == sse_pkg::OP_COPROC2_ST) begin
            op = sse_pkg::SSE_OP_COP_STORE;
        end
    end

    always_comb begin
        shift_amt = issue.source_reg_a[sse_pkg::SHIFT_W-1:0];
        shift_res = issue.second_operand_reg[31:0] >> shift_amt;
        diff = {1'b0, issue.source_reg_a[31:0]}
             + {1'b0, ~issue.second_operand_reg[31:0]} + 33'h0_0000_0001;
        // carry into bit 31 equals sum bit xor both operand bits
        carry30 = diff[31] ^ issue.source_reg_a[31]
                ^ ~issue.second_operand_reg[31];
        overflow = carry30 ^ diff[32];
    end

    assign issue_ready = (r.state == SSE_IDLE);
    assign wb          = r.wb;
    assign store_req   = r.st;
    assign exc_valid   = r.exc_valid;
    assign exc_code    = r.exc_code;
    assign store_done  = r.store_done;

    always_comb begin
        next_r = r;
        next_r.wb.valid   = 1'b0;
        next_r.exc_valid  = 1'b0;
        next_r.store_done = 1'b0;
        case (r.state)
            SSE_IDLE: begin
                if (issue.valid) begin
                    case (op)
                        sse_pkg::SSE_OP_SHIFT: begin
                            next_r.wb.valid = 1'b1;
                            next_r.wb.dest  =
                                issue.instr[sse_pkg::DEST_HI:sse_pkg::DEST_LO];
                            next_r.wb.value = {{32{shift_res[31]}}, shift_res};
                        end
                        sse_pkg::SSE_OP_CHECKED,
                        sse_pkg::SSE_OP_WRAPPING: begin
                            if (op == sse_pkg::SSE_OP_CHECKED && overflow) begin
                                next_r.exc_valid = 1'b1;
                                next_r.exc_code  = sse_pkg::SSE_EXC_OVERFLOW;
                            end else begin
                                // wrapping form ignores overflow
                                next_r.wb.valid = 1'b1;
                                next_r.wb.dest  = issue.instr[
                                    sse_pkg::DEST_HI:sse_pkg::DEST_LO];
                                next_r.wb.value =
                                    {{32{diff[31]}}, diff[31:0]};
                            end
                        end
                        sse_pkg::SSE_OP_STORE,
                        sse_pkg::SSE_OP_COP_STORE: begin
                            next_r.st.from_coproc =
                                (op == sse_pkg::SSE_OP_COP_STORE);
                            next_r.st.coproc_num = opc[1:0];
                            next_r.st.coproc_reg = issue.instr[
                                sse_pkg::SECB_HI:sse_pkg::SECB_LO];
                            next_r.st.vaddr = vaddr;
                            next_r.st.data  =
                                issue.second_operand_reg[31:0];
                            if (op == sse_pkg::SSE_OP_COP_STORE
                                && opc[1:0] == 2'b00) begin
                                next_r.exc_valid = 1'b1;
                                next_r.exc_code  = sse_pkg::SSE_EXC_RESERVED;
                            end else if (op == sse_pkg::SSE_OP_COP_STORE
                                && !(opc[1:0] == 2'b01 ? issue.cop_usable1
                                                       : issue.cop_usable2))
                                begin
                                next_r.exc_valid = 1'b1;
                                next_r.exc_code  =
                                    sse_pkg::SSE_EXC_COP_UNUSABLE;
                            end else if (misaligned) begin
                                // no request leaves, memory untouched
                                next_r.exc_valid = 1'b1;
                                next_r.exc_code  = sse_pkg::SSE_EXC_ADDR_ERR;
                            end else if (op == sse_pkg::SSE_OP_COP_STORE) begin
                                // word is fetched before the request rises
                                next_r.state = SSE_FETCH;
                            end else begin
                                next_r.st.valid = 1'b1;
                                next_r.state    = SSE_REQ;
                            end
                        end
                        default: begin
                            next_r.wb.valid = 1'b0;
                        end
                    endcase
                end
            end
            SSE_FETCH: begin
                // data must hold while the request waits for acceptance
                next_r.st.data  = coproc_data;
                next_r.st.valid = 1'b1;
                next_r.state    = SSE_REQ;
            end
            SSE_REQ: begin
                if (store_ready) begin
                    next_r.st.valid = 1'b0;
                    next_r.state    = SSE_WAIT;
                end
            end
            SSE_WAIT: begin
                // block stays busy so no later instruction retires
                if (mem_resp.done) begin
                    next_r.state = SSE_IDLE;
                    next_r.exc_valid = 1'b1;
                    if (mem_resp.tlb_miss) begin
                        next_r.exc_code = sse_pkg::SSE_EXC_TLB_MISS;
                    end else if (mem_resp.tlb_invalid) begin
                        next_r.exc_code = sse_pkg::SSE_EXC_TLB_INVALID;
                    end else if (mem_resp.tlb_mod) begin
                        next_r.exc_code = sse_pkg::SSE_EXC_TLB_MOD;
                    end else if (mem_resp.bus_error) begin
                        next_r.exc_code = sse_pkg::SSE_EXC_RESERVED;
                    end else begin
                        next_r.exc_valid  = 1'b0;
                        next_r.exc_code   = sse_pkg::SSE_EXC_NONE;
                        next_r.store_done = 1'b1;
                    end
                end
            end
            default: begin
                next_r.state = SSE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r.state        <= SSE_IDLE;
            r.wb.valid     <= 1'b0;
            r.wb.dest      <= 5'h00;
            r.wb.value     <= sse_pkg::RESULT_RESET;
            r.st           <= '0;
            r.exc_valid    <= 1'b0;
            r.exc_code     <= sse_pkg::SSE_EXC_NONE;
            r.store_done   <= 1'b0;
        end else begin
            r <= next_r;
        end
    end
endmodule

// File: sim/sse_exec_checker.sv
// port assertions for the execution block
`timescale 1ns/1ps
module sse_exec_checker (
    input wire logic                      clk,
    input wire logic                      rst_n,
    input wire sse_pkg::sse_issue_type    issue,
    input wire logic                      issue_ready,
    input wire sse_pkg::sse_wb_type       wb,
    input wire sse_pkg::sse_store_type    store_req,
    input wire logic                      store_ready,
    input wire sse_pkg::sse_mem_resp_type mem_resp,
    input wire logic                      exc_valid,
    input wire sse_pkg::sse_exc_type      exc_code,
    input wire logic                      store_done
);
    logic wrap_taken;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk) begin
        wrap_taken <= rst_n && issue.valid && issue_ready
            && issue.instr[31:26] == sse_pkg::OP_REG_FORMAT
            && issue.instr[10:6] == 5'h00
            && issue.instr[5:0] == sse_pkg::FN_WRAPPING;
    end
    sequence s_req_wait;
        store_req.valid && !store_ready;
    endsequence
    sequence s_miss;
        mem_resp.done && mem_resp.tlb_miss;
    endsequence
    chk_req_hold: assert property (s_req_wait |=> store_req.valid
        && $stable(store_req.data) && $stable(store_req.vaddr))
        else $error("store request changed before acceptance");
    chk_word_align: assert property (store_req.valid
        |-> store_req.vaddr[1:0] == 2'h0)
        else $error("misaligned store sent to memory");
    chk_no_cop0: assert property (store_req.valid
        && store_req.from_coproc |-> store_req.coproc_num != 2'h0)
        else $error("coprocessor zero store sent to memory");
    chk_ovf_no_wb: assert property (exc_valid
        && exc_code == sse_pkg::SSE_EXC_OVERFLOW |-> !wb.valid)
        else $error("write-back beside overflow");
    chk_wb_sext: assert property (wb.valid
        |-> wb.value[63:32] == {32{wb.value[31]}})
        else $error("result not sign-extended");
    chk_store_busy: assert property (store_req.valid |-> !issue_ready)
        else $error("issue accepted during store");
    chk_miss_exc: assert property (s_miss
        |=> exc_valid && exc_code == sse_pkg::SSE_EXC_TLB_MISS)
        else $error("translation miss not reported");
    chk_done_clean: assert property (store_done |-> $past(mem_resp.done)
        && !$past(mem_resp.bus_error) && !$past(mem_resp.tlb_mod))
        else $error("store done without clean response");
    chk_wrap_noexc: assert property (wrap_taken
        |-> wb.valid && !exc_valid)
        else $error("wrapping difference raised exception");
endmodule
bind sse_exec sse_exec_checker u_chk (.clk(clk), .rst_n(rst_n),
    .issue(issue), .issue_ready(issue_ready), .wb(wb),
    .store_req(store_req), .store_ready(store_ready),
    .mem_resp(mem_resp), .exc_valid(exc_valid), .exc_code(exc_code),
    .store_done(store_done));

// File: sim/sse_mem_model.sv
// far side model: translation, memory and coprocessor data
`timescale 1ns/1ps
module sse_mem_model (
    input  wire logic                      clk,
    input  wire sse_pkg::sse_store_type    store_req,
    input  wire sse_pkg::sse_mem_resp_type fault,
    input  wire logic [1:0]                lat,
    output logic                           store_ready,
    output logic [31:0]                    coproc_data,
    output sse_pkg::sse_mem_resp_type      mem_resp
);
    logic [1:0] w = 2'h0;
    logic       pend = 1'b0;
    initial begin
        store_ready = 1'b0;
        mem_resp = '0;
    end
    // word tied to register number; inverted unless a coprocessor is asked
    assign coproc_data = {store_req.coproc_reg, 3'h5, 24'hc0_ffee}
        ^ {32{~store_req.from_coproc}};
    always @(posedge clk) begin
        #1;
        mem_resp = '0;
        if (store_ready) begin
            store_ready = 1'b0;
            pend = 1'b1;
            w = lat;
        end else if (pend) begin
            if (w == 2'h0) begin
                mem_resp = fault;
                mem_resp.done = 1'b1;
                pend = 1'b0;
            end else w--;
        end else if (store_req.valid) begin
            if (w == lat) store_ready = 1'b1;
            else w++;
        end
    end
endmodule

// File: sim/tb_top.sv
// self-checking bench for the execution block
`timescale 1ns/1ps
module tb_top;
    logic                      clk = 1'b0;
    logic                      rst_n = 1'b0;
    sse_pkg::sse_issue_type    issue = '0;
    logic                      issue_ready;
    sse_pkg::sse_wb_type       wb;
    sse_pkg::sse_store_type    store_req;
    logic                      store_ready;
    logic [31:0]               coproc_data;
    sse_pkg::sse_mem_resp_type mem_resp;
    logic                      exc_valid;
    sse_pkg::sse_exc_type      exc_code;
    logic                      store_done;
    sse_pkg::sse_mem_resp_type fault = '0;
    logic [1:0]                lat = 2'h0;
    int                        error_cnt = 0;
    int                        n_compared = 0;
    int                        cyc = 0;
    logic [31:0]               seed = 32'hdca5_89a4;
    logic [71:0]               exp_q[$];
    always #2.5 clk = ~clk;
    sse_exec uut (.clk(clk), .rst_n(rst_n), .issue(issue),
        .issue_ready(issue_ready), .wb(wb), .store_req(store_req),
        .store_ready(store_ready), .coproc_data(coproc_data),
        .mem_resp(mem_resp), .exc_valid(exc_valid), .exc_code(exc_code),
        .store_done(store_done));
    sse_mem_model u_mem (.clk(clk), .store_req(store_req), .fault(fault),
        .lat(lat), .store_ready(store_ready), .coproc_data(coproc_data),
        .mem_resp(mem_resp));
    function automatic logic [71:0] ex(input logic [2:0] c);
        return {3'd2, 66'd0, c};
    endfunction
    task check(input string what, input logic [71:0] seen,
        input logic [71:0] want);
        n_compared++;
        if (seen !== want) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", what, want, seen);
        end
    endtask
    task tally_and_finish;
        if (error_cnt == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task pop(input string what, input logic [71:0] o);
        if (exp_q.size() == 0) check(what, o, 'x);
        else check(what, o, exp_q.pop_front());
    endtask
    // a new issue only goes out while idle, else valid is dropped
    task wait_idle;
        int n;
        n = 0;
        while (issue_ready !== 1'b1 && n < 100) begin
            issue.valid = 1'b0;
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    // fault and latency of a store stay put until the block is idle again
    task send(input sse_pkg::sse_issue_type x);
        issue = x;
        @(posedge clk);
        #1;
    endtask
    initial begin
        logic [31:0] r, d;
        logic [63:0] a, b, va;
        logic [2:0] k, ec;
        sse_pkg::sse_issue_type x;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 500; i++) begin
            wait_idle;
            r = $random(seed);
            a = {$random(seed), $random(seed)};
            b = {$random(seed), $random(seed)};
            if (r[3]) a[1:0] = 2'h0;
            k = r[2:0];
            x = '0;
            x.valid = 1'b1;
            x.source_reg_a = a;
            x.second_operand_reg = b;
            x.mode64 = r[9];
            x.cop_usable1 = r[10];
            x.cop_usable2 = r[11];
            if (k < 3 || k == 7) begin
                x.instr = {6'h00, r[20:11], r[8:4], k == 7 ? 5'h01 : 5'h00,
                    k == 0 ? sse_pkg::FN_SHIFT_RV : k == 2
                    ? sse_pkg::FN_WRAPPING : sse_pkg::FN_CHECKED};
                d = k == 0 ? b[31:0] >> a[4:0] : a[31:0] - b[31:0];
                if (k == 1 && a[31] != b[31] && d[31] != a[31])
                    exp_q.push_back(ex(sse_pkg::SSE_EXC_OVERFLOW));
                else if (k != 7) exp_q.push_back({3'd1, r[8:4],
                    {{32{d[31]}}, d}});
            end else begin
                x.instr = {k == 3 ? sse_pkg::OP_WORD_STORE : {4'he, k[1:0]},
                    r[25:16], r[31:16]};
                va = a + {{48{r[31]}}, r[31:16]};
                d = k == 3 ? b[31:0] : {r[20:16], 3'h5, 24'hc0_ffee};
                fault = r[12] ? {1'b0, r[16:13]} : '0;
                lat = r[27:26];
                ec = fault.tlb_miss ? sse_pkg::SSE_EXC_TLB_MISS
                    : fault.tlb_invalid ? sse_pkg::SSE_EXC_TLB_INVALID
                    : fault.tlb_mod ? sse_pkg::SSE_EXC_TLB_MOD
                    : sse_pkg::SSE_EXC_RESERVED;
                if (k == 4) exp_q.push_back(ex(sse_pkg::SSE_EXC_RESERVED));
                else if ((k == 5 && !r[10]) || (k == 6 && !r[11]))
                    exp_q.push_back(ex(sse_pkg::SSE_EXC_COP_UNUSABLE));
                else if (va[1:0] != 2'h0)
                    exp_q.push_back(ex(sse_pkg::SSE_EXC_ADDR_ERR));
                else begin
                    exp_q.push_back({3'd4, 5'd0, d, va[31:0]});
                    exp_q.push_back(fault[3:0] != 4'h0 ? ex(ec)
                        : {3'd3, 69'd0});
                end
            end
            send(x);
        end
        issue.valid = 1'b0;
        repeat (20) @(posedge clk);
        check("queue empty", 72'(exp_q.size()), 72'd0);
        tally_and_finish;
    end
    always @(posedge clk) begin
        cyc++;
        if (rst_n) begin
            if (wb.valid)
                pop("write-back", {3'd1, wb.dest, wb.value});
            if (exc_valid)
                pop("exception", ex(exc_code));
            if (store_done)
                pop("store done", {3'd3, 69'd0});
            if (store_req.valid && store_ready)
                pop("store request", {3'd4, 5'd0, store_req.data,
                    store_req.vaddr[31:0]});
        end
        if (cyc == 30000) begin
            error_cnt++;
            tally_and_finish;
        end
    end
endmodule
